// ===== verilog/clock_buffer_regs.svh
// byte offsets, field positions, reset values and timing counts of the clock buffer control
// assumes a 10 MHz system clock; included by the control block and its testbench
`ifndef CLOCK_BUFFER_REGS_SVH
`define CLOCK_BUFFER_REGS_SVH

`define OFS_PLL_MODE 8'h01
`define OFS_OE_BITS 8'h02
`define OFS_STOP_STATE 8'h0b

`define MODE_RB_LSB 6
`define MODE_CTL_LSB 3
`define STOP_TRUE_BIT 1
`define STOP_COMP_BIT 0

`define MODE_LO_BW 2'h0
`define MODE_BYPASS 2'h1
`define MODE_HI_BW 2'h3

`define ADDR_STRAP_LO 7'h6b
`define ADDR_STRAP_MID 7'h6c
`define ADDR_STRAP_HI 7'h6d

`define OE_BITS_RESET 6'h3f
`define STOP_STATE_RESET 2'h0

`define SYS_CLK_KHZ 10000
`define LOS_DETECT_MS 6
`define LOS_DETECT_CYC (`LOS_DETECT_MS * `SYS_CLK_KHZ)
`define LOS_RELEASE_US 500
`define LOS_REL_EDGES 3'h4
`define DRVPD_US 300
`define DRVPD_CYC (`DRVPD_US * `SYS_CLK_KHZ / 1000)

`endif

// ===== verilog/clock_buffer_pkg.sv
// types shared by the clock buffer control block and its management bus target
// no assumptions beyond a SystemVerilog package scope
package clock_buffer_pkg;
	typedef enum logic [1:0] {PW_WAIT, PW_RUN, PW_DOWN} pwr_state_e;
	typedef enum logic [2:0] {T_IDLE, T_ADDR, T_CMD, T_WDATA, T_RDATA} target_state_e;
endpackage

// ===== verilog/smbus_target.sv
// two-wire management bus target: address match, command byte, byte writes and reads
// assumes scl and sda already pass through two synchronising flip-flops upstream
`timescale 1ns/100ps
module smbus_target
	import clock_buffer_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic active_in,
	input wire logic [6:0] dev_addr_in,
	input wire logic [7:0] rd_data_in,
	output logic [7:0] ptr_out,
	output logic [7:0] wr_data_out,
	output logic wr_en_out,
	output logic sda_oe_out
);
	target_state_e state_q;
	logic scl_q, sda_q, ack_q, rw_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q, tx_q;

	wire start_det = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_det = scl_in & scl_q & ~sda_q & sda_in;
	wire rise = scl_in & ~scl_q;
	wire fall = ~scl_in & scl_q;
	wire [2:0] tx_idx = 3'(4'h7 - cnt_q);

	always_ff @(posedge sys_clk_in) begin
		scl_q <= scl_in;
		sda_q <= sda_in;
	end

	// ack is driven across the whole ninth bit: from the eighth fall to the ninth fall
	always_ff @(posedge sys_clk_in) begin
		wr_en_out <= 1'b0;
		if (rst_in || !active_in || stop_det) begin
			state_q <= T_IDLE;
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			sda_oe_out <= 1'b0;
			if (rst_in) begin
				ptr_out <= 8'h00;
				wr_data_out <= 8'h00;
				sh_q <= 8'h00;
				tx_q <= 8'h00;
				rw_q <= 1'b0;
			end
		end else if (start_det) begin
			state_q <= T_ADDR;
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (state_q != T_IDLE && rise) begin
			if (cnt_q != 4'h8) begin
				sh_q <= {sh_q[6:0], sda_in};
				cnt_q <= cnt_q + 4'h1;
			end else begin
				cnt_q <= 4'h0;
				if (state_q == T_RDATA) begin
					if (sda_in)
						state_q <= T_IDLE;
					else
						ptr_out <= ptr_out + 8'h01;
				end
			end
		end else if (state_q != T_IDLE && fall) begin
			if (cnt_q == 4'h8) begin
				ack_q <= 1'b1;
				case (state_q)
					T_ADDR: begin
						if (sh_q[7:1] == dev_addr_in) begin
							rw_q <= sh_q[0];
							sda_oe_out <= 1'b1;
						end else begin
							state_q <= T_IDLE;
						end
					end
					T_CMD: begin
						ptr_out <= sh_q;
						sda_oe_out <= 1'b1;
					end
					T_WDATA: begin
						wr_data_out <= sh_q;
						wr_en_out <= 1'b1;
						sda_oe_out <= 1'b1;
					end
					default: sda_oe_out <= 1'b0;
				endcase
			end else if (cnt_q == 4'h0 && ack_q) begin
				ack_q <= 1'b0;
				sda_oe_out <= 1'b0;
				case (state_q)
					T_ADDR: begin
						state_q <= rw_q ? T_RDATA : T_CMD;
						if (rw_q) begin
							tx_q <= rd_data_in;
							sda_oe_out <= ~rd_data_in[7];
						end
					end
					T_CMD: state_q <= T_WDATA;
					T_WDATA: ptr_out <= ptr_out + 8'h01;
					T_RDATA: begin
						tx_q <= rd_data_in;
						sda_oe_out <= ~rd_data_in[7];
					end
					default: state_q <= T_IDLE;
				endcase
			end else if (state_q == T_RDATA) begin
				sda_oe_out <= ~tx_q[tx_idx];
			end
		end
	end
endmodule

// ===== verilog/clock_buffer_output_control.sv
// control logic of a six-output differential clock fanout buffer with a zero-delay pll
// assumes an analog pll outside that takes pll_enable_out and returns its clock and lock
`timescale 1ns/100ps
`include "clock_buffer_regs.svh"
module clock_buffer_output_control
	import clock_buffer_pkg::*;
#(
	parameter int unsigned LOS_DETECT_CYC = `LOS_DETECT_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ref_clk_in,
	input wire logic pll_clk_in,
	input wire logic pll_lock_in,
	input wire logic power_good_powerdown_n_in,
	input wire logic [5:0] output_enable_pin_n_in,
	input wire logic [1:0] bus_address_strap_in,
	input wire logic [1:0] bandwidth_bypass_strap_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic los_out,
	output logic los_oe_out,
	output logic [5:0] diff_clock_output_t_out,
	output logic [5:0] diff_clock_output_c_out,
	output logic pll_enable_out,
	output logic pll_high_bw_out
);
	logic [15:0] meta_q, sync_q;
	pwr_state_e state_q;
	logic [1:0] strap_code_q, mode_ctl_q, stop_q;
	logic [6:0] dev_addr_q;
	logic [5:0] oe_bit_q, run_q, run_d;
	logic src_q, ref_prev_q, los_q;
	logic [16:0] gap_q;
	logic [2:0] rel_q;
	logic [7:0] ptr, wr_data, rd_data;
	logic wr_en, sda_oe;

	// every pin goes through two flops; only sync_q is read by logic
	wire [15:0] pins_raw = {power_good_powerdown_n_in, output_enable_pin_n_in,
		bus_address_strap_in, bandwidth_bypass_strap_in, ref_clk_in, pll_clk_in,
		pll_lock_in, scl_in, sda_in};

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			meta_q <= 16'h0000;
			sync_q <= 16'h0000;
		end else begin
			meta_q <= pins_raw;
			sync_q <= meta_q;
		end
	end

	wire pg_s = sync_q[15];
	wire [5:0] oe_pin_s = sync_q[14:9];
	wire [1:0] addr_strap_s = sync_q[8:7];
	wire [1:0] mode_strap_s = sync_q[6:5];
	wire ref_s = sync_q[4];
	wire pll_s = sync_q[3];
	wire lock_s = sync_q[2];
	wire scl_s = sync_q[1];
	wire sda_s = sync_q[0];

	// strap pins arrive as 00 low, 01 mid, 11 high; a stray 10 is taken as mid
	wire [1:0] mode_strap_code = (mode_strap_s == 2'h2) ? `MODE_BYPASS : mode_strap_s;
	wire [6:0] addr_sel = (addr_strap_s == 2'h0) ? `ADDR_STRAP_LO :
		(addr_strap_s == 2'h3) ? `ADDR_STRAP_HI : `ADDR_STRAP_MID;
	wire pg_first = (state_q == PW_WAIT) && pg_s;

	wire bypass = (mode_ctl_q != `MODE_LO_BW) && (mode_ctl_q != `MODE_HI_BW);
	wire src = bypass ? ref_s : pll_s;
	wire src_fall = src_q & ~src;
	wire allow = (state_q == PW_RUN) && (bypass || lock_s);
	wire [5:0] want = oe_bit_q & ~oe_pin_s;

	wire wr_mode = wr_en && (ptr == `OFS_PLL_MODE);
	wire wr_oe = wr_en && (ptr == `OFS_OE_BITS);
	wire wr_stop = wr_en && (ptr == `OFS_STOP_STATE);
	wire [7:0] mode_byte = (8'(strap_code_q) << `MODE_RB_LSB) | (8'(mode_ctl_q) << `MODE_CTL_LSB);
	assign rd_data = (ptr == `OFS_PLL_MODE) ? mode_byte :
		(ptr == `OFS_OE_BITS) ? {2'h0, oe_bit_q} :
		(ptr == `OFS_STOP_STATE) ? {6'h00, stop_q} : 8'h00;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= PW_WAIT;
			strap_code_q <= `MODE_BYPASS;
			mode_ctl_q <= `MODE_BYPASS;
			dev_addr_q <= `ADDR_STRAP_MID;
		end else begin
			case (state_q)
				PW_WAIT: if (pg_s) begin
					strap_code_q <= mode_strap_code;
					mode_ctl_q <= mode_strap_code;
					dev_addr_q <= addr_sel;
					state_q <= PW_RUN;
				end
				PW_RUN: if (!pg_s) state_q <= PW_DOWN;
				PW_DOWN: if (pg_s) state_q <= PW_RUN;
				default: state_q <= PW_WAIT;
			endcase
			if (wr_mode)
				mode_ctl_q <= wr_data[`MODE_CTL_LSB +: 2];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			oe_bit_q <= `OE_BITS_RESET;
			stop_q <= `STOP_STATE_RESET;
		end else begin
			if (wr_oe)
				oe_bit_q <= wr_data[5:0];
			if (wr_stop)
				stop_q <= wr_data[1:0];
		end
	end

	// gates change only at a falling source edge, so no runt pulse reaches a pair while the stop state is 01 (true low, complement high);
	// dropping out of run, or losing lock outside bypass, stops the pairs at once
	assign run_d = !allow ? 6'h00 : (src_fall ? want : run_q);

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			src_q <= 1'b0;
			run_q <= 6'h00;
			diff_clock_output_t_out <= 6'h00;
			diff_clock_output_c_out <= 6'h00;
			pll_enable_out <= 1'b0;
			pll_high_bw_out <= 1'b0;
		end else begin
			src_q <= src;
			run_q <= run_d;
			diff_clock_output_t_out <= (run_q & {6{src}}) |
				(~run_q & {6{stop_q[`STOP_TRUE_BIT]}});
			diff_clock_output_c_out <= (run_q & {6{~src}}) |
				(~run_q & {6{stop_q[`STOP_COMP_BIT]}});
			pll_enable_out <= (state_q == PW_RUN) && !bypass;
			pll_high_bw_out <= (mode_ctl_q == `MODE_HI_BW);
		end
	end

	// loss detector: a silent input for the detect count sets the flag,
	// a few edges in a row clear it; starts flagged until edges are seen
	wire ref_edge = ref_s ^ ref_prev_q;
	wire gap_full = (gap_q >= 17'(LOS_DETECT_CYC - 1));

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ref_prev_q <= 1'b0;
			gap_q <= 17'h00000;
			rel_q <= 3'h0;
			los_q <= 1'b1;
			los_oe_out <= 1'b0;
		end else begin
			ref_prev_q <= ref_s;
			if (ref_edge) begin
				gap_q <= 17'h00000;
				if (los_q) begin
					rel_q <= rel_q + 3'h1;
					if (rel_q == `LOS_REL_EDGES - 3'h1)
						los_q <= 1'b0;
				end
			end else if (gap_full) begin
				los_q <= 1'b1;
				rel_q <= 3'h0;
			end else begin
				gap_q <= gap_q + 17'h00001;
			end
			los_oe_out <= ~los_q;
		end
	end

	assign los_out = 1'b0;
	assign sda_out = 1'b0;

	smbus_target u_target (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.scl_in(scl_s),
		.sda_in(sda_s),
		.active_in(state_q != PW_WAIT),
		.dev_addr_in(dev_addr_q),
		.rd_data_in(rd_data),
		.ptr_out(ptr),
		.wr_data_out(wr_data),
		.wr_en_out(wr_en),
		.sda_oe_out(sda_oe)
	);

	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			sda_oe_out <= 1'b0;
		else
			sda_oe_out <= sda_oe;
	end

	AST_PD_STOPS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state_q == PW_DOWN)[*2] |=> (diff_clock_output_t_out == {6{$past(stop_q[1])}}) &&
		(diff_clock_output_c_out == {6{$past(stop_q[0])}}))
		else $error("pair not stopped in power-down");
	AST_PLL_OFF_PD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state_q != PW_RUN) |=> !pll_enable_out)
		else $error("pll enabled outside run");
	AST_BYPASS_PLL: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(bypass && $stable(mode_ctl_q)) |=> !pll_enable_out)
		else $error("pll enabled in bypass");
	AST_LOCK_BLOCK: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(!bypass && !lock_s) |=> (run_q == 6'h00))
		else $error("output running before lock");
	AST_BIT_DISABLE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(!oe_bit_q[0] && src_fall) |=> !run_q[0])
		else $error("cleared enable bit left output running");
	AST_PIN_DISABLE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(oe_pin_s[5] && src_fall) |=> !run_q[5])
		else $error("high enable pin left output running");
	AST_RUN_ON_EDGE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(run_q[1]) |-> $past(src_fall))
		else $error("output started away from a source edge");
	AST_ADDR_LATCH: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		pg_first && (addr_strap_s == 2'h0) |=> (dev_addr_q == 7'h6b) [*2])
		else $error("low address strap gave wrong address");
	AST_MODE_DEFAULT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		pg_first && (mode_strap_s == 2'h1) |=> bypass && (strap_code_q == 2'h1))
		else $error("mid mode strap did not select bypass");
	AST_LOS_SET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(gap_full && !ref_edge) |=> los_q ##1 !los_oe_out)
		else $error("loss not flagged after silent input");
endmodule

// ===== tb/bus_host_model.sv
// management bus host model: start, stop and nine-bit byte transfers
// assumes the bench resolves the data wire from both pull-down enables with a pull-up
`timescale 1ns/100ps
module bus_host_model (
	input wire logic sys_clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic phase();
		repeat (10) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic start();
		sda_low_out = 1'b1;
		phase();
		scl_out = 1'b0;
		phase();
	endtask
	task automatic stop();
		phase();
		sda_low_out = 1'b1;
		phase();
		scl_out = 1'b1;
		phase();
		sda_low_out = 1'b0;
		phase();
	endtask
	// data moves a full phase after scl falls so the target never sees a false start or stop
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 8; i >= 0; i--) begin
			phase();
			sda_low_out = (i > 0) ? !tx[i-1] : 1'b0;
			phase();
			scl_out = 1'b1;
			phase();
			r = sda_in;
			scl_out = 1'b0;
			if (i > 0) rx[i-1] = r;
		end
		ack = !r;
	endtask
endmodule

// ===== tb/clock_buffer_output_control_tb_top.sv
// bench of the clock buffer control: straps, enables, stop level, power-down, modes, loss flag
// assumes the design files and the bus host model are compiled before it
`timescale 1ns/100ps
`include "clock_buffer_regs.svh"
module clock_buffer_output_control_tb_top;
	logic sys_clk, rst, ref_clk, ref_run, lock, pg, ack;
	logic [5:0] pin_n, t, c, hi, lo, chi;
	logic [1:0] adr_strap, mode_strap;
	logic scl, sda_low, sda_oe, los_oe, pll_en, pll_hbw, sda_lvl, los_lvl;
	logic [7:0] rd;
	logic [6:0] dev_addr;
	logic [1:0] codes [4] = '{`MODE_LO_BW, `MODE_BYPASS, `MODE_HI_BW, 2'h2};
	int err_total = 0;
	int tests_run = 0;
	// both lines float to their pull-ups unless something drives them low
	wire sda = !sda_low & (!sda_oe | sda_lvl);
	wire los_pin = !los_oe | los_lvl;
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// a stopped input clock freezes at its last level, as a dead source would
	initial begin
		ref_clk = 1'b0;
		forever #400 if (ref_run) ref_clk = ~ref_clk;
	end
	clock_buffer_output_control #(.LOS_DETECT_CYC(200)) dut (
		.sys_clk_in(sys_clk), .rst_in(rst), .ref_clk_in(ref_clk), .pll_clk_in(ref_clk),
		.pll_lock_in(lock), .power_good_powerdown_n_in(pg), .output_enable_pin_n_in(pin_n),
		.bus_address_strap_in(adr_strap), .bandwidth_bypass_strap_in(mode_strap),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_lvl), .sda_oe_out(sda_oe), .los_out(los_lvl),
		.los_oe_out(los_oe), .diff_clock_output_t_out(t), .diff_clock_output_c_out(c),
		.pll_enable_out(pll_en), .pll_high_bw_out(pll_hbw));
	bus_host_model host (.sys_clk_in(sys_clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic obs(input int n);
		hi = 6'h00;
		lo = 6'h00;
		chi = 6'h00;
		repeat (n) begin
			step(1);
			hi |= t;
			lo |= ~t;
			chi |= c;
		end
	endtask
	task automatic reg_wr(input logic [7:0] off, input logic [7:0] d);
		logic a;
		logic [7:0] x;
		host.start();
		host.xfer({dev_addr, 1'b0}, x, a);
		check("addr ack", {7'h0, a}, 8'h01);
		host.xfer(off, x, a);
		check("offset ack", {7'h0, a}, 8'h01);
		host.xfer(d, x, a);
		check("data ack", {7'h0, a}, 8'h01);
		host.stop();
	endtask
	task automatic reg_rd(input logic [7:0] off, input logic [7:0] exp);
		logic a;
		logic [7:0] x;
		host.start();
		host.xfer({dev_addr, 1'b0}, x, a);
		host.xfer(off, x, a);
		host.stop();
		host.start();
		host.xfer({dev_addr, 1'b1}, x, a);
		check("read ack", {7'h0, a}, 8'h01);
		host.xfer(8'hff, x, a);
		check("read data", x, exp);
		host.stop();
	endtask
	initial begin
		rst = 1'b1;
		pg = 1'b0;
		dev_addr = `ADDR_STRAP_MID;
		ref_run = 1'b1;
		lock = 1'b0;
		pin_n = 6'h00;
		adr_strap = 2'h1;
		mode_strap = 2'h1;
		step(5);
		rst = 1'b0;
		obs(20);
		check("t before pg", {2'h0, hi}, 8'h00);
		check("pll before pg", {7'h0, pll_en}, 8'h00);
		pg = 1'b1;
		// no bus traffic until power-good has been seen
		step(100);
		obs(40);
		check("t high", {2'h0, hi}, 8'h3f);
		check("t low", {2'h0, lo}, 8'h3f);
		check("pll bypass", {7'h0, pll_en}, 8'h00);
		check("los present", {7'h0, los_pin}, 8'h00);
		reg_rd(`OFS_PLL_MODE, 8'h48);
		reg_rd(`OFS_OE_BITS, 8'h3f);
		reg_rd(`OFS_STOP_STATE, 8'h00);
		reg_rd(8'h05, 8'h00);
		host.start();
		host.xfer({`ADDR_STRAP_LO, 1'b0}, rd, ack);
		check("foreign addr ack", {7'h0, ack}, 8'h00);
		host.stop();
		reg_wr(`OFS_STOP_STATE, 8'h02);
		reg_wr(`OFS_OE_BITS, 8'h3e);
		pin_n = 6'h02;
		// three input clock periods is the longest the enable pin may take
		step(24);
		obs(40);
		check("disabled t low", {2'h0, lo}, 8'h3c);
		check("disabled t high", {2'h0, hi}, 8'h3f);
		check("disabled c high", {2'h0, chi}, 8'h3c);
		pg = 1'b0;
		step(6);
		obs(40);
		check("pd t low", {2'h0, lo}, 8'h00);
		check("pd c high", {2'h0, chi}, 8'h00);
		check("pd pll", {7'h0, pll_en}, 8'h00);
		pg = 1'b1;
		step(3000);
		obs(40);
		check("resume t low", {2'h0, lo}, 8'h3c);
		reg_wr(`OFS_PLL_MODE, 8'h18);
		step(20);
		obs(40);
		check("unlocked t low", {2'h0, lo}, 8'h00);
		lock = 1'b1;
		step(40);
		obs(40);
		check("locked t low", {2'h0, lo}, 8'h3c);
		reg_rd(`OFS_PLL_MODE, 8'h58);
		// 00 and 11 run the pll; 01 and the unused 10 bypass it
		for (int i = 0; i < 4; i++) begin
			reg_wr(`OFS_PLL_MODE, {3'h0, codes[i], 3'h0});
			step(10);
			check("pll on", {7'h0, pll_en}, {7'h0, codes[i][1] == codes[i][0]});
			check("high bw", {7'h0, pll_hbw}, {7'h0, codes[i] == `MODE_HI_BW});
		end
		ref_run = 1'b0;
		step(150);
		check("los held", {7'h0, los_pin}, 8'h00);
		step(60);
		check("los flagged", {7'h0, los_pin}, 8'h01);
		ref_run = 1'b1;
		step(40);
		check("los cleared", {7'h0, los_pin}, 8'h00);
		// second reset with other straps: the new address and mode must be latched
		rst = 1'b1;
		adr_strap = 2'h0;
		mode_strap = 2'h3;
		step(5);
		rst = 1'b0;
		step(60);
		adr_strap = 2'h1;
		dev_addr = `ADDR_STRAP_LO;
		check("strap pll hi bw", {6'h00, pll_en, pll_hbw}, 8'h03);
		reg_rd(`OFS_PLL_MODE, 8'hd8);
		stop_test();
	end
	initial begin
		#6000000;
		err_total++;
		stop_test();
	end
endmodule
